// ### rtl/rtc_timer_control.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - control bit 7 turns the oscillator and its bias currents on or off
// - control bit 6 enables the missing-clock detector
// - bit 5 set by hardware on missing-clock timeout, held until software clears
// - bit 4 runs the timer; when clear the count holds
// - bit 3 enables the alarm; writing the register clears the alarm flag
// - reading bit 2 returns the alarm event flag
// - writing bit 2 sets auto reset, not the alarm flag
// - writing 1 to bit 1 loads the timer; bit clears when done
// - writing 1 to bit 0 snapshots the timer; bit clears when done
// - alarm flag drops by itself within one oscillator cycle
// - running timer increments once per oscillator cycle
// - alarm fires when timer equals alarm compare value
// - with auto reset, timer clears one oscillator cycle after alarm
// - load copies holding into timer, snapshot copies timer into holding
module rtc_timer_control
	import rtc_pkg::*;
#(
	parameter int MISS_COUNT = MISS_CYCLES
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic osc_pin,
	output logic osc_enable,
	output logic alarm_event,
	output logic irq
);

	rtc_ctrl_t ctrl;
	rtc_ctrl_t wctrl;
	rtc_ctrl_t rd_ctrl;
	logic ph_valid;
	logic ph_write;
	logic [ADDR_W-1:0] ph_addr;
	logic wr_now;
	logic wr_ctrl;
	logic wr_hold;
	logic wr_alarm;
	logic wr_stat;
	logic wr_mask;
	logic rd_fill;
	logic [31:0] rd_mux;
	logic [31:0] timer;
	logic [31:0] next_timer;
	logic [31:0] holding;
	logic [31:0] alarm_compare;
	logic alarm_flag;
	logic alarm_hit;
	logic auto_pend;
	logic osc_tick;
	logic miss_pulse;
	logic fail_set;
	logic load_done;
	logic snap_done;
	logic [INT_W-1:0] int_stat;
	logic [INT_W-1:0] int_mask;
	logic [INT_W-1:0] int_event;

	// ----------------------------------------
	// oscillator monitor
	// ----------------------------------------
	rtc_osc_monitor #(
		.MISS_COUNT(MISS_COUNT)
	) u_monitor (
		.clock(clock),
		.rst(rst),
		.osc_pin(osc_pin),
		.enable(ctrl.missing_clock_detect_on),
		.osc_tick(osc_tick),
		.miss_pulse(miss_pulse)
	);

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= '0;
		end
		else if (hready)
		begin
			ph_valid <= hsel && htrans[1] && hsize == SIZE_WORD;
			ph_write <= hwrite;
			ph_addr <= haddr[ADDR_W-1:0];
		end
	end

	// reads take one wait state so a write just before is always seen
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			hreadyout <= 1'b1;
		else if (hready && hsel && htrans[1] && !hwrite && hsize == SIZE_WORD)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	assign hresp = 1'b0;
	assign wr_now = ph_valid && ph_write && hready;
	assign wr_ctrl = wr_now && ph_addr == ADDR_CTRL;
	assign wr_hold = wr_now && ph_addr == ADDR_HOLD;
	assign wr_alarm = wr_now && ph_addr == ADDR_ALARM;
	assign wr_stat = wr_now && ph_addr == ADDR_INT_STAT;
	assign wr_mask = wr_now && ph_addr == ADDR_INT_MASK;
	assign rd_fill = ph_valid && !ph_write && !hreadyout;
	assign wctrl = rtc_ctrl_t'(hwdata[7:0]);

	always_comb
	begin
		rd_ctrl = ctrl;
		rd_ctrl.alarm_flag_autoreset = alarm_flag;
		case (ph_addr)
			ADDR_HOLD: rd_mux = holding;
			ADDR_CTRL: rd_mux = {24'h000000, rd_ctrl};
			ADDR_ALARM: rd_mux = alarm_compare;
			ADDR_INT_STAT: rd_mux = {28'h0000000, int_stat};
			ADDR_INT_MASK: rd_mux = {28'h0000000, int_mask};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (rd_fill)
			hrdata <= rd_mux;
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	assign fail_set = miss_pulse && ctrl.missing_clock_detect_on;
	assign load_done = osc_tick && ctrl.timer_load_go;
	assign snap_done = osc_tick && ctrl.timer_snapshot_go;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ctrl <= rtc_ctrl_t'(CTRL_RESET);
		else
		begin
			if (wr_ctrl)
			begin
				ctrl.osc_on <= wctrl.osc_on;
				ctrl.missing_clock_detect_on <= wctrl.missing_clock_detect_on;
				ctrl.timer_run <= wctrl.timer_run;
				ctrl.alarm_on <= wctrl.alarm_on;
				ctrl.alarm_flag_autoreset <= wctrl.alarm_flag_autoreset;
			end
			if (fail_set)
				ctrl.osc_fail_flag <= 1'b1;
			else if (wr_ctrl)
				ctrl.osc_fail_flag <= wctrl.osc_fail_flag;
			if (wr_ctrl && wctrl.timer_load_go)
				ctrl.timer_load_go <= 1'b1;
			else if (load_done)
				ctrl.timer_load_go <= 1'b0;
			if (wr_ctrl && wctrl.timer_snapshot_go)
				ctrl.timer_snapshot_go <= 1'b1;
			else if (snap_done)
				ctrl.timer_snapshot_go <= 1'b0;
		end
	end

	assign osc_enable = ctrl.osc_on;

	// ----------------------------------------
	// timer and alarm
	// ----------------------------------------
	always_comb
	begin
		// load takes priority over auto reset
		if (ctrl.timer_load_go)
			next_timer = holding;
		else if (auto_pend)
			next_timer = TIMER_RESET;
		else if (ctrl.timer_run)
			next_timer = timer + 32'h0000_0001;
		else
			next_timer = timer;
	end

	// match only on a fresh value, so a stopped timer fires once
	assign alarm_hit = osc_tick && ctrl.alarm_on && next_timer == alarm_compare && next_timer != timer;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			timer <= TIMER_RESET;
			auto_pend <= 1'b0;
		end
		else if (osc_tick)
		begin
			timer <= next_timer;
			auto_pend <= alarm_hit && ctrl.alarm_flag_autoreset;
		end
	end

	// flag lasts at most one oscillator cycle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			alarm_flag <= 1'b0;
		else if (alarm_hit)
			alarm_flag <= 1'b1;
		else if (wr_ctrl || osc_tick)
			alarm_flag <= 1'b0;
	end

	assign alarm_event = alarm_flag;

	// snapshot wins over a bus write in the same cycle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			holding <= HOLD_RESET;
		else if (snap_done)
			holding <= timer;
		else if (wr_hold)
			holding <= hwdata;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			alarm_compare <= ALARM_RESET;
		else if (wr_alarm)
			alarm_compare <= hwdata;
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_comb
	begin
		int_event = '0;
		int_event[INT_ALARM] = alarm_hit;
		int_event[INT_OSC_FAIL] = fail_set;
		int_event[INT_LOAD_DONE] = load_done;
		int_event[INT_SNAP_DONE] = snap_done;
	end

	// write one to clear; a new event in the same cycle stays set
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			int_stat <= INT_RESET;
		else if (wr_stat)
			int_stat <= (int_stat & ~hwdata[INT_W-1:0]) | int_event;
		else
			int_stat <= int_stat | int_event;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			int_mask <= INT_RESET;
		else if (wr_mask)
			int_mask <= hwdata[INT_W-1:0];
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(int_stat & int_mask);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_load_req;
		wr_ctrl && wctrl.timer_load_go;
	endsequence

	sequence s_load_tick;
		ctrl.timer_load_go && osc_tick;
	endsequence

	sequence s_snap_tick;
		ctrl.timer_snapshot_go && osc_tick;
	endsequence

	sequence s_alarm_arm;
		alarm_hit && ctrl.alarm_flag_autoreset;
	endsequence

	sequence s_alarm_auto;
		auto_pend && osc_tick && !ctrl.timer_load_go;
	endsequence

	chk_osc_enable_write: assert property (
		wr_ctrl |=> osc_enable == $past(hwdata[7]))
		else $error("oscillator enable did not follow write");

	chk_detect_gates_fail: assert property (
		!ctrl.missing_clock_detect_on && !wr_ctrl |=> ctrl.osc_fail_flag == $past(ctrl.osc_fail_flag))
		else $error("fail flag moved with detector off");

	chk_fail_sticky: assert property (
		fail_set || (ctrl.osc_fail_flag && !wr_ctrl) |=> ctrl.osc_fail_flag)
		else $error("fail flag not set or not held");

	chk_timer_hold: assert property (
		osc_tick && !ctrl.timer_run && !ctrl.timer_load_go && !auto_pend |=> $stable(timer))
		else $error("stopped timer changed");

	chk_alarm_write_clear: assert property (
		wr_ctrl && !alarm_hit |=> !alarm_flag)
		else $error("control write did not clear alarm flag");

	chk_flag_readback: assert property (
		rd_fill && ph_addr == ADDR_CTRL |=> hrdata[2] == $past(alarm_flag))
		else $error("alarm flag not returned on read");

	chk_autoreset_write: assert property (
		wr_ctrl |=> ctrl.alarm_flag_autoreset == $past(hwdata[2]) && (alarm_flag || !$past(alarm_hit)))
		else $error("auto reset write wrong or flag touched");

	chk_load_go_held: assert property (
		s_load_req ##1 (!osc_tick)[*3] |-> ctrl.timer_load_go)
		else $error("load bit dropped before done");

	chk_load_copy: assert property (
		s_load_tick |=> timer == $past(holding) && (!ctrl.timer_load_go || $past(wr_ctrl)))
		else $error("load did not copy holding or clear bit");

	chk_snap_copy: assert property (
		(s_snap_tick and !wr_ctrl) |=> holding == $past(timer) && !ctrl.timer_snapshot_go)
		else $error("snapshot did not copy timer or clear bit");

	chk_flag_expires: assert property (
		alarm_flag && osc_tick && !alarm_hit |=> !alarm_flag)
		else $error("alarm flag outlived one oscillator cycle");

	chk_timer_count: assert property (
		osc_tick && ctrl.timer_run && !ctrl.timer_load_go && !auto_pend |=> timer == $past(timer) + 32'h0000_0001)
		else $error("running timer did not increment by one");

	chk_alarm_match: assert property (
		alarm_hit && !wr_alarm |=> alarm_flag && timer == alarm_compare)
		else $error("alarm hit without flag or match");

	chk_auto_clear: assert property (
		s_alarm_auto |=> timer == TIMER_RESET)
		else $error("auto reset did not clear timer");

	chk_auto_arm: assert property (
		s_alarm_arm |=> auto_pend)
		else $error("auto reset not armed by alarm");

	chk_zero_ignored: assert property (
		ctrl.timer_load_go && wr_ctrl && !wctrl.timer_load_go && !osc_tick |=> ctrl.timer_load_go)
		else $error("writing zero aborted a load");

	chk_irq_level: assert property (
		|(int_stat & int_mask) |=> irq)
		else $error("irq missing for unmasked status");

endmodule // rtc_timer_control
`default_nettype wire

// ### include/rtc_pkg.sv
`default_nettype none
package rtc_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MISS_TIME_NS = 100000;
	// least time, rounded up to whole cycles
	localparam int MISS_CYCLES = (MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_HOLD = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_ALARM = 8'h14;
	localparam logic [7:0] ADDR_INT_STAT = 8'h18;
	localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	// ----------------------------------------
	// interrupt status layout
	// ----------------------------------------
	localparam int INT_W = 4;
	localparam int INT_ALARM = 0;
	localparam int INT_OSC_FAIL = 1;
	localparam int INT_LOAD_DONE = 2;
	localparam int INT_SNAP_DONE = 3;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
	localparam logic [31:0] HOLD_RESET = 32'h0000_0000;
	localparam logic [31:0] ALARM_RESET = 32'h0000_0000;
	localparam logic [3:0] INT_RESET = 4'h0;

	// ----------------------------------------
	// control register layout, bit 7 first
	// ----------------------------------------
	typedef struct packed {
		logic osc_on;
		logic missing_clock_detect_on;
		logic osc_fail_flag;
		logic timer_run;
		logic alarm_on;
		logic alarm_flag_autoreset;
		logic timer_load_go;
		logic timer_snapshot_go;
	} rtc_ctrl_t;

endpackage
`default_nettype wire

// ### rtl/rtc_osc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_osc_monitor
	import rtc_pkg::*;
#(
	parameter int MISS_COUNT = MISS_CYCLES
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic osc_pin,
	input wire logic enable,
	output logic osc_tick,
	output logic miss_pulse
);

	localparam int CW = $clog2(MISS_COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(MISS_COUNT - 1);
	localparam logic [CW-1:0] FULL = CW'(MISS_COUNT);

	logic sync1;
	logic sync2;
	logic sync3;
	logic edge_seen;
	logic [CW-1:0] quiet;

	// ----------------------------------------
	// pin synchroniser and edge detect
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			osc_tick <= 1'b0;
		end
		else
		begin
			sync1 <= osc_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			osc_tick <= sync2 & ~sync3;
		end
	end

	assign edge_seen = sync2 ^ sync3;

	// ----------------------------------------
	// missing clock one-shot
	// ----------------------------------------
	// counts only while enabled
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			quiet <= '0;
			miss_pulse <= 1'b0;
		end
		else
		begin
			miss_pulse <= enable && !edge_seen && quiet == LAST;
			if (!enable || edge_seen)
				quiet <= '0;
			else if (quiet != FULL)
				quiet <= quiet + CW'(1);
		end
	end

endmodule // rtc_osc_monitor
`default_nettype wire

// ### bench/test_rtc_timer_control.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bench for the timer control block
// ----------------------------------------
module test_rtc_timer_control
	import rtc_pkg::*;
;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} rtc_row_t;

	logic clock, rst, hsel, hwrite, osc_pin, osc_enable, alarm_event, irq, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int failures, num_checks;
	rtc_row_t rows [15];

	// small miss count keeps the detector test short
	rtc_timer_control #(.MISS_COUNT(20)) i_rtc_timer_control (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_pin(osc_pin), .osc_enable(osc_enable),
		.alarm_event(alarm_event), .irq(irq));

	always #5 clock = ~clock;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// bounded: a slave that never answers ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			failures++;
			$display("[FAIL] %0t bus wait expired", $time);
			summarize();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rdat = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h00000000);
		check(rdat, e, what);
	endtask

	// n slow-clock cycles, pin stable well over two system clocks per level
	task automatic osc_ticks(input int n);
		repeat (n)
		begin
			osc_pin <= 1'b1;
			repeat (4) @(posedge clock);
			osc_pin <= 1'b0;
			repeat (4) @(posedge clock);
		end
	endtask

	// go bits only finish on a slow-clock tick, so tick until the bit drops
	task automatic poll_clear(input int b);
		int n;
		for (n = 0; n < 10; n++)
		begin
			osc_ticks(1);
			bus(1'b0, ADDR_CTRL, 32'h00000000);
			if (rdat[b] === 1'b0)
				break;
		end
		check({31'h0, rdat[b]}, 32'h00000000, "go bit clear");
		// a go bit stuck high ends the run here
		if (rdat[b] !== 1'b0)
			summarize();
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = SIZE_WORD;
		hwdata = 32'h00000000;
		osc_pin = 1'b0;
		failures = 0;
		num_checks = 0;
		rows = '{'{1'b0, ADDR_CTRL, 32'h0, {24'h0, CTRL_RESET}}, '{1'b0, ADDR_HOLD, 32'h0, HOLD_RESET},
			'{1'b0, ADDR_ALARM, 32'h0, ALARM_RESET}, '{1'b0, ADDR_INT_STAT, 32'h0, {28'h0, INT_RESET}},
			'{1'b0, ADDR_INT_MASK, 32'h0, {28'h0, INT_RESET}}, '{1'b1, ADDR_HOLD, 32'h12345678, 32'h0},
			'{1'b0, ADDR_HOLD, 32'h0, 32'h12345678}, '{1'b1, ADDR_ALARM, 32'hA5A50001, 32'h0},
			'{1'b0, ADDR_ALARM, 32'h0, 32'hA5A50001}, '{1'b1, 8'h20, 32'hFFFFFFFF, 32'h0},
			'{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, ADDR_CTRL, 32'hFFFFFF84, 32'h0},
			'{1'b0, ADDR_CTRL, 32'h0, 32'h00000080}, '{1'b1, ADDR_HOLD, 32'h000000F0, 32'h0},
			'{1'b0, ADDR_HOLD, 32'h0, 32'h000000F0}};
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check({31'h0, irq}, 32'h0, "irq after reset");
		check({31'h0, hresp}, 32'h0, "okay response");
		// register table, write of bit 2 leaves flag low
		foreach (rows[i])
		begin
			if (rows[i].w)
				bus(1'b1, rows[i].a, rows[i].d);
			else
				rd(rows[i].a, rows[i].e, "table read");
		end
		check({31'h0, osc_enable}, 32'h1, "osc enable on");
		bus(1'b1, ADDR_CTRL, 32'h00000002);
		bus(1'b1, ADDR_CTRL, 32'h00000000);
		check({31'h0, osc_enable}, 32'h0, "osc enable off");
		rd(ADDR_CTRL, 32'h00000002, "load pending kept");
		poll_clear(1);
		bus(1'b1, ADDR_CTRL, 32'h00000010);
		osc_ticks(5);
		bus(1'b1, ADDR_CTRL, 32'h00000011);
		poll_clear(0);
		rd(ADDR_HOLD, 32'h000000F5, "load then count");
		bus(1'b1, ADDR_CTRL, 32'h00000000);
		osc_ticks(3);
		bus(1'b1, ADDR_CTRL, 32'h00000001);
		poll_clear(0);
		rd(ADDR_HOLD, 32'h000000F6, "stopped timer holds");
		bus(1'b1, ADDR_ALARM, 32'h000000F8);
		bus(1'b1, ADDR_INT_MASK, 32'h00000001);
		bus(1'b1, ADDR_CTRL, 32'h0000001C);
		osc_ticks(1);
		check({31'h0, alarm_event}, 32'h0, "no early alarm");
		osc_ticks(1);
		check({31'h0, alarm_event}, 32'h1, "alarm on match");
		check({31'h0, irq}, 32'h1, "irq on alarm");
		rd(ADDR_CTRL, 32'h0000001C, "flag readable");
		osc_ticks(1);
		check({31'h0, alarm_event}, 32'h0, "flag self clears");
		bus(1'b1, ADDR_CTRL, 32'h00000001);
		poll_clear(0);
		rd(ADDR_HOLD, 32'h00000000, "auto reset to zero");
		rd(ADDR_INT_STAT, 32'h0000000D, "sticky status");
		bus(1'b1, ADDR_INT_STAT, 32'h00000001);
		repeat (2) @(posedge clock);
		// masked load and snapshot bits must not hold irq up
		check({31'h0, irq}, 32'h0, "irq cleared");
		rd(ADDR_INT_STAT, 32'h0000000C, "one bit cleared");
		// a byte-sized write is refused and leaves holding alone
		hsize <= 3'h0;
		bus(1'b1, ADDR_HOLD, 32'h00005A5A);
		hsize <= SIZE_WORD;
		rd(ADDR_HOLD, 32'h00000000, "narrow write ignored");
		bus(1'b1, ADDR_CTRL, 32'h00000040);
		repeat (60) @(posedge clock);
		rd(ADDR_CTRL, 32'h00000060, "osc fail set");
		rd(ADDR_INT_STAT, 32'h0000000E, "osc fail status");
		bus(1'b1, ADDR_CTRL, 32'h00000000);
		repeat (60) @(posedge clock);
		rd(ADDR_CTRL, 32'h00000000, "detector off");
		// second alarm, then a control write before the next tick
		bus(1'b1, ADDR_ALARM, 32'h00000002);
		bus(1'b1, ADDR_CTRL, 32'h00000018);
		osc_ticks(2);
		check({31'h0, alarm_event}, 32'h1, "second alarm");
		bus(1'b1, ADDR_CTRL, 32'h00000010);
		@(posedge clock);
		check({31'h0, alarm_event}, 32'h0, "write clears flag");
		check({31'h0, irq}, 32'h1, "irq before reset");
		// reset in mid-run must bring irq, ready, control and interrupt status back
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check({31'h0, irq}, 32'h0, "irq after second reset");
		check({31'h0, hreadyout}, 32'h1, "ready after second reset");
		rd(ADDR_CTRL, {24'h000000, CTRL_RESET}, "control after second reset");
		rd(ADDR_INT_STAT, {28'h0000000, INT_RESET}, "status after second reset");
		summarize();
	end
endmodule // test_rtc_timer_control
`default_nettype wire
